// ==== tcs_defs.vh ====
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH

// timing figures in their own units
`define TCS_T_OFF_US 100
`define TCS_T_ON_MS 2
`define TCS_T_2W_MS 300
`define TCS_T_START_MS 300
`define TCS_T_COOLED_S 90
`define TCS_T_HPE_MS 300
`define TCS_T_PDOWN_MS 300
`define TCS_T_FAULT_MS 1
`define TCS_T_FAULT_COOLED_MS 50
`define TCS_T_RESET_US 10
`define TCS_T_RS_FC_US 500
`define TCS_T_RS_MS 24
`define TCS_T_LOS_US 100
`define TCS_CLK_KHZ 25000

// register byte addresses
`define TCS_A_CTRL 4'h0
`define TCS_A_STAT 4'h4
`define TCS_A_IRQ_ST 4'h8
`define TCS_A_IRQ_EN 4'hC

// control field positions
`define TCS_C_COOLED 0
`define TCS_C_FC 1
`define TCS_C_HPE 2
`define TCS_CTRL_W 3

// status field positions
`define TCS_S_READY2W 0
`define TCS_S_OPER 1
`define TCS_S_TXON 2
`define TCS_S_FAULT 3
`define TCS_S_LOS 4
`define TCS_S_RATEOK 5
`define TCS_S_HIPWR 6
`define TCS_STAT_W 7

// event bits
`define TCS_E_FAULT 0
`define TCS_E_LOS 1
`define TCS_E_OPER 2
`define TCS_E_RATE 3
`define TCS_EV_W 4

`endif

// ==== tcs_sequencer.v ====
`include "tcs_defs.vh"
module tcs_sequencer #(
    parameter T_2W_CYC = (`TCS_T_2W_MS * `TCS_CLK_KHZ) - 1,
    parameter T_START_CYC = (`TCS_T_START_MS * `TCS_CLK_KHZ) - 1,
    parameter [31:0] T_COOLED_CYC = (`TCS_T_COOLED_S * 32'd1000 * `TCS_CLK_KHZ) - 32'd1,
    parameter T_HPE_CYC = (`TCS_T_HPE_MS * `TCS_CLK_KHZ) - 1,
    parameter T_PDOWN_CYC = (`TCS_T_PDOWN_MS * `TCS_CLK_KHZ) - 1,
    parameter T_ON_CYC = (`TCS_T_ON_MS * `TCS_CLK_KHZ) - 1,
    parameter T_FAULT_CYC = (`TCS_T_FAULT_MS * `TCS_CLK_KHZ) - 1,
    parameter T_FAULT_COOLED_CYC = (`TCS_T_FAULT_COOLED_MS * `TCS_CLK_KHZ) - 1,
    parameter T_RS_CYC = (`TCS_T_RS_MS * `TCS_CLK_KHZ) - 1,
    parameter T_RS_FC_CYC = (`TCS_T_RS_FC_US * `TCS_CLK_KHZ) / 1000 - 1,
    parameter T_RESET_CYC = (`TCS_T_RESET_US * `TCS_CLK_KHZ + 999) / 1000,
    parameter T_LOS_CYC = (`TCS_T_LOS_US * `TCS_CLK_KHZ) / 1000 - 1
) (
    input wire REF_CLK, // 25 MHz clock
    input wire RST, // power-on / hot-plug reset, async high
    input wire LASER_DISABLE, // host laser disable, high = off
    input wire RATE_SELECT_LOW, // rate select input 0
    input wire RATE_SELECT_HIGH, // rate select input 1
    input wire LASER_FAULT_RAW, // raw laser fault detector
    input wire SIGNAL_LOST_RAW, // raw receive signal loss detector
    output reg TX_ENABLE, // laser drive enable
    output reg LASER_FAULT, // fault flag, high = fault
    output reg SIGNAL_LOSS, // signal loss flag, high = lost
    output reg RATE_STABLE, // output stable at selected rate
    output reg HIGH_POWER, // high power level in effect
    output reg OPERATIONAL, // fully operational
    output reg MGMT_READY, // management interface ready
    output wire IRQ, // level interrupt
    input wire WB_CYC_I, // wishbone cycle
    input wire WB_STB_I, // wishbone strobe
    input wire WB_WE_I, // wishbone write enable
    input wire [3:0] WB_ADR_I, // wishbone byte address
    input wire [3:0] WB_SEL_I, // wishbone byte selects
    input wire [31:0] WB_DAT_I, // wishbone write data
    output reg [31:0] WB_DAT_O, // wishbone read data
    output reg WB_ACK_O // wishbone acknowledge
);

localparam CW = 32;
localparam [4:0] S_INIT = 5'h01;
localparam [4:0] S_OFF = 5'h02;
localparam [4:0] S_WARM = 5'h04;
localparam [4:0] S_RUN = 5'h08;
localparam [4:0] S_FAULT = 5'h10;

reg [4:0] st_q;
reg [CW-1:0] seq_cnt_q;
reg [CW-1:0] mgmt_cnt_q;
reg [CW-1:0] pwr_cnt_q;
reg [CW-1:0] flt_cnt_q;
reg [CW-1:0] rate_cnt_q;
reg [CW-1:0] rst_cnt_q;
reg [CW-1:0] los_cnt_q;
reg [`TCS_CTRL_W-1:0] ctrl_q;
reg [`TCS_EV_W-1:0] irq_st_q;
reg [`TCS_EV_W-1:0] irq_en_q;
reg hpe_prev_q;
reg rs0_q;
reg rs1_q;
reg fault_prev_q;
reg los_prev_q;
reg oper_prev_q;
reg rate_prev_q;
reg cleared_q;
reg init_q;

wire cooled = ctrl_q[`TCS_C_COOLED];
wire fc_rate = ctrl_q[`TCS_C_FC];
wire hpe = ctrl_q[`TCS_C_HPE];
wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
wire warm_lim_hit;
wire [CW-1:0] warm_lim;
wire [CW-1:0] flt_lim;
wire [CW-1:0] pwr_lim;
wire [CW-1:0] rate_lim;
wire warm_done;
wire [`TCS_EV_W-1:0] ev;

assign warm_lim_hit = (seq_cnt_q >= warm_lim);

// saturating count helper used by every timer
function [CW-1:0] inc_sat;
    input [CW-1:0] v;
    begin
        inc_sat = (v == {CW{1'b1}}) ? v : v + {{(CW-1){1'b0}}, 1'b1};
    end
endfunction

// pick one of two limits by a configuration bit
function [CW-1:0] cfg_pick;
    input sel;
    input [CW-1:0] lim_set;
    input [CW-1:0] lim_clr;
    begin
        cfg_pick = sel ? lim_set : lim_clr;
    end
endfunction

assign warm_lim = cfg_pick(cooled, T_COOLED_CYC, T_START_CYC);
assign flt_lim = cfg_pick(cooled, T_FAULT_COOLED_CYC, T_FAULT_CYC);
assign pwr_lim = hpe ? cfg_pick(cooled, T_COOLED_CYC, T_HPE_CYC) : T_PDOWN_CYC;
assign rate_lim = cfg_pick(fc_rate, T_RS_FC_CYC, T_RS_CYC);
assign warm_done = init_q ? warm_lim_hit : ((seq_cnt_q >= T_ON_CYC) || warm_lim_hit);

// main sequencer; counters run on the reference clock, reset restarts
// clocked restartable counters
always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
        st_q <= S_INIT;
        seq_cnt_q <= {CW{1'b0}};
        TX_ENABLE <= 1'b0;
        OPERATIONAL <= 1'b0;
        HIGH_POWER <= 1'b0;
        pwr_cnt_q <= {CW{1'b0}};
        hpe_prev_q <= 1'b0;
        cleared_q <= 1'b0;
        init_q <= 1'b1;
    end else begin
        hpe_prev_q <= hpe;
        case (st_q)
            S_INIT: begin
                TX_ENABLE <= 1'b0;
                OPERATIONAL <= 1'b0;
                if (LASER_DISABLE) begin
                    st_q <= S_OFF;
                end else begin
                    st_q <= S_WARM;
                    seq_cnt_q <= {CW{1'b0}};
                end
            end
            S_OFF: begin
                TX_ENABLE <= 1'b0;
                OPERATIONAL <= 1'b0;
                if (!LASER_DISABLE) begin
                    seq_cnt_q <= {CW{1'b0}};
                    st_q <= S_WARM;
                end
            end
            S_WARM: begin
                seq_cnt_q <= inc_sat(seq_cnt_q);
                if (LASER_DISABLE) begin
                    TX_ENABLE <= 1'b0;
                    st_q <= S_OFF;
                end else if (LASER_FAULT) begin
                    TX_ENABLE <= 1'b0;
                    st_q <= S_FAULT;
                end else if (warm_done) begin
                    TX_ENABLE <= 1'b1;
                    OPERATIONAL <= 1'b1;
                    init_q <= 1'b0;
                    st_q <= S_RUN;
                end else begin
                    TX_ENABLE <= ~init_q;
                end
            end
            S_RUN: begin
                if (LASER_DISABLE) begin
                    TX_ENABLE <= 1'b0;
                    OPERATIONAL <= 1'b0;
                    st_q <= S_OFF;
                end else if (LASER_FAULT) begin
                    TX_ENABLE <= 1'b0;
                    OPERATIONAL <= 1'b0;
                    st_q <= S_FAULT;
                end
            end
            S_FAULT: begin
                TX_ENABLE <= 1'b0;
                OPERATIONAL <= 1'b0;
                cleared_q <= 1'b0;
                // a hold of one cycle less than the reset time is enough
                if (rst_cnt_q >= T_RESET_CYC - 1) begin
                    cleared_q <= 1'b1;
                end
                if (!LASER_DISABLE && cleared_q) begin
                    seq_cnt_q <= {CW{1'b0}};
                    init_q <= 1'b1;
                    st_q <= S_WARM;
                end
            end
            default: begin
                st_q <= S_INIT;
            end
        endcase
        if (hpe != hpe_prev_q) begin
            pwr_cnt_q <= {CW{1'b0}};
        end else if (hpe != HIGH_POWER) begin
            pwr_cnt_q <= inc_sat(pwr_cnt_q);
            if (pwr_cnt_q >= pwr_lim) begin
                HIGH_POWER <= hpe;
            end
        end
    end
end

always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
        mgmt_cnt_q <= {CW{1'b0}};
        MGMT_READY <= 1'b0;
    end else if (!MGMT_READY) begin
        mgmt_cnt_q <= inc_sat(mgmt_cnt_q);
        if (mgmt_cnt_q >= T_2W_CYC) begin
            MGMT_READY <= 1'b1;
        end
    end
end

// fault qualify and latch; disable hold time counted for clearing
always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
        flt_cnt_q <= {CW{1'b0}};
        rst_cnt_q <= {CW{1'b0}};
        LASER_FAULT <= 1'b0;
    end else begin
        rst_cnt_q <= LASER_DISABLE ? inc_sat(rst_cnt_q) : {CW{1'b0}};
        if (!LASER_FAULT) begin
            flt_cnt_q <= LASER_FAULT_RAW ? inc_sat(flt_cnt_q) : {CW{1'b0}};
            if (LASER_FAULT_RAW && flt_cnt_q >= flt_lim) begin
                LASER_FAULT <= 1'b1;
            end
        end else if (st_q == S_FAULT && !LASER_DISABLE && cleared_q) begin
            LASER_FAULT <= 1'b0;
            flt_cnt_q <= {CW{1'b0}};
        end
    end
end

// rate change settle timer
// rate settle limit
always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
        rs0_q <= 1'b0;
        rs1_q <= 1'b0;
        rate_cnt_q <= {CW{1'b0}};
        RATE_STABLE <= 1'b0;
    end else begin
        rs0_q <= RATE_SELECT_LOW;
        rs1_q <= RATE_SELECT_HIGH;
        if ((rs0_q != RATE_SELECT_LOW) || (rs1_q != RATE_SELECT_HIGH)) begin
            rate_cnt_q <= {CW{1'b0}};
            RATE_STABLE <= 1'b0;
        end else if (!RATE_STABLE) begin
            rate_cnt_q <= inc_sat(rate_cnt_q);
            if (rate_cnt_q >= rate_lim) begin
                RATE_STABLE <= 1'b1;
            end
        end
    end
end

// signal loss filter, symmetric in both directions
always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
        los_cnt_q <= {CW{1'b0}};
        SIGNAL_LOSS <= 1'b1;
    end else if (SIGNAL_LOST_RAW != SIGNAL_LOSS) begin
        los_cnt_q <= inc_sat(los_cnt_q);
        if (los_cnt_q >= T_LOS_CYC) begin
            SIGNAL_LOSS <= SIGNAL_LOST_RAW;
            los_cnt_q <= {CW{1'b0}};
        end
    end else begin
        los_cnt_q <= {CW{1'b0}};
    end
end

assign ev[`TCS_E_FAULT] = LASER_FAULT & ~fault_prev_q;
assign ev[`TCS_E_LOS] = SIGNAL_LOSS ^ los_prev_q;
assign ev[`TCS_E_OPER] = OPERATIONAL & ~oper_prev_q;
assign ev[`TCS_E_RATE] = RATE_STABLE & ~rate_prev_q;
assign IRQ = |(irq_st_q & irq_en_q);

// wishbone slave, registered ack one cycle after each request
always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h0000_0000;
        ctrl_q <= {`TCS_CTRL_W{1'b0}};
        irq_st_q <= {`TCS_EV_W{1'b0}};
        irq_en_q <= {`TCS_EV_W{1'b0}};
        fault_prev_q <= 1'b0;
        los_prev_q <= 1'b1;
        oper_prev_q <= 1'b0;
        rate_prev_q <= 1'b0;
    end else begin
        fault_prev_q <= LASER_FAULT;
        los_prev_q <= SIGNAL_LOSS;
        oper_prev_q <= OPERATIONAL;
        rate_prev_q <= RATE_STABLE;
        WB_ACK_O <= wb_req;
        // set wins over a clear in the same cycle
        if (wb_wr && WB_ADR_I == `TCS_A_IRQ_ST) begin
            irq_st_q <= (irq_st_q & ~WB_DAT_I[`TCS_EV_W-1:0]) | ev;
        end else begin
            irq_st_q <= irq_st_q | ev;
        end
        if (wb_wr && WB_ADR_I == `TCS_A_CTRL) begin
            ctrl_q <= WB_DAT_I[`TCS_CTRL_W-1:0];
        end
        if (wb_wr && WB_ADR_I == `TCS_A_IRQ_EN) begin
            irq_en_q <= WB_DAT_I[`TCS_EV_W-1:0];
        end
        if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
                `TCS_A_CTRL: WB_DAT_O <= {{(32-`TCS_CTRL_W){1'b0}}, ctrl_q};
                `TCS_A_STAT: WB_DAT_O <= {{(32-`TCS_STAT_W){1'b0}}, HIGH_POWER, RATE_STABLE,
                    SIGNAL_LOSS, LASER_FAULT, TX_ENABLE, OPERATIONAL, MGMT_READY};
                `TCS_A_IRQ_ST: WB_DAT_O <= {{(32-`TCS_EV_W){1'b0}}, irq_st_q};
                `TCS_A_IRQ_EN: WB_DAT_O <= {{(32-`TCS_EV_W){1'b0}}, irq_en_q};
                default: WB_DAT_O <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule

// ==== tcs_host_model.sv ====
module tcs_host_model #(
    parameter int T_RESET_CYC = 5
) (
    input wire REF_CLK, // clock
    output logic LASER_DISABLE, // laser disable
    output logic RATE_SELECT_LOW, // rate 0
    output logic RATE_SELECT_HIGH // rate 1
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        LASER_DISABLE = 1'b0;
        RATE_SELECT_LOW = 1'b0;
        RATE_SELECT_HIGH = 1'b0;
    end
    task automatic set_disable(input logic v);
        @(posedge REF_CLK);
        LASER_DISABLE <= v;
    endtask
    task automatic clear_fault();
        set_disable(1'b1);
        repeat (T_RESET_CYC + 2) @(posedge REF_CLK);
        set_disable(1'b0);
    endtask
    task automatic set_rate(input logic lo, input logic hi);
        @(posedge REF_CLK);
        RATE_SELECT_LOW <= lo;
        RATE_SELECT_HIGH <= hi;
    endtask
endmodule

// ==== tcs_properties.sv ====
module tcs_properties #(
    parameter int T_2W_CYC = 20,
    parameter int T_START_CYC = 20,
    parameter int T_FAULT_COOLED_CYC = 20,
    parameter int T_LOS_CYC = 20
) (
    input wire REF_CLK, // clock
    input wire RST, // reset
    input wire LASER_DISABLE, // disable
    input wire LASER_FAULT_RAW, // raw fault
    input wire SIGNAL_LOST_RAW, // raw loss
    input wire TX_ENABLE, // laser on
    input wire LASER_FAULT, // fault flag
    input wire SIGNAL_LOSS, // loss flag
    input wire OPERATIONAL, // operational
    input wire MGMT_READY, // mgmt ready
    input wire WB_CYC_I, // cycle
    input wire WB_STB_I, // strobe
    input wire WB_ACK_O // ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_q, los_cnt_q, flt_cnt_q;
    logic los_raw_q;
    // time since reset, steady time of raw loss input and high time of raw fault input
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 32'h0;
            los_cnt_q <= 32'h0;
            flt_cnt_q <= 32'h0;
            los_raw_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            los_raw_q <= SIGNAL_LOST_RAW;
            los_cnt_q <= (SIGNAL_LOST_RAW != los_raw_q) ? 32'h0 : los_cnt_q + 32'h1;
            flt_cnt_q <= LASER_FAULT_RAW ? flt_cnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    a_laser_off: assert property (LASER_DISABLE && $past(LASER_DISABLE) && $past(LASER_DISABLE, 2) |-> !TX_ENABLE)
        else $error("laser on while disabled");
    a_ready_early: assert property ((cnt_q < T_2W_CYC - 1) |-> !MGMT_READY)
        else $error("ready too early");
    a_ready_late: assert property ((cnt_q > T_2W_CYC + 3) |-> MGMT_READY)
        else $error("ready too late");
    a_oper_early: assert property ((cnt_q < T_START_CYC - 1) |-> !OPERATIONAL)
        else $error("operational too early");
    a_fault_flag: assert property ((flt_cnt_q > T_FAULT_COOLED_CYC + 3) |-> LASER_FAULT)
        else $error("fault flag late");
    a_fault_sticky: assert property (LASER_FAULT && !LASER_DISABLE && !$past(LASER_DISABLE)
        && !$past(LASER_DISABLE, 2) && !$past(LASER_DISABLE, 3) |=> LASER_FAULT)
        else $error("fault cleared without disable");
    a_loss_follow: assert property ((los_cnt_q > T_LOS_CYC + 3) |-> SIGNAL_LOSS == los_raw_q)
        else $error("loss flag wrong");
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    cover property ($rose(LASER_FAULT));
    cover property ($rose(SIGNAL_LOSS));
    cover property ($fell(TX_ENABLE));
endmodule
bind tcs_sequencer tcs_properties #(.T_2W_CYC(T_2W_CYC), .T_START_CYC(T_START_CYC),
    .T_FAULT_COOLED_CYC(T_FAULT_COOLED_CYC), .T_LOS_CYC(T_LOS_CYC)) tcs_properties_i (.REF_CLK, .RST,
    .LASER_DISABLE, .LASER_FAULT_RAW, .SIGNAL_LOST_RAW, .TX_ENABLE, .LASER_FAULT, .SIGNAL_LOSS,
    .OPERATIONAL, .MGMT_READY, .WB_CYC_I, .WB_STB_I, .WB_ACK_O);

// ==== transceiver_control_status_timing_test.sv ====
module transceiver_control_status_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P_2W = 30, P_START = 40, P_COOLED = 60, P_HPE = 20, P_PDOWN = 24, P_ON = 16;
    localparam int P_FAULT = 10, P_FLTC = 14, P_RS = 18, P_RS_FC = 8, P_RESET = 5, P_LOS = 6;
    logic ref_clk = 1'b0, rst = 1'b1, fault_raw = 1'b0, lost_raw = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    wire laser_disable, rsl, rsh, tx_en, fault, loss, rate_ok, hi_pwr, oper, ready, irq, ack;
    wire [31:0] rdat;
    wire [7:0] outs = {irq, ready, oper, hi_pwr, rate_ok, loss, fault, tx_en};
    int n_mismatch = 0;
    int n_checks = 0;
    tcs_host_model #(.T_RESET_CYC(P_RESET)) tcs_host_model_i (.REF_CLK(ref_clk), .LASER_DISABLE(laser_disable),
        .RATE_SELECT_LOW(rsl), .RATE_SELECT_HIGH(rsh));
    tcs_sequencer #(.T_2W_CYC(P_2W), .T_START_CYC(P_START), .T_COOLED_CYC(P_COOLED), .T_HPE_CYC(P_HPE),
        .T_PDOWN_CYC(P_PDOWN), .T_ON_CYC(P_ON), .T_FAULT_CYC(P_FAULT), .T_FAULT_COOLED_CYC(P_FLTC),
        .T_RS_CYC(P_RS), .T_RS_FC_CYC(P_RS_FC), .T_RESET_CYC(P_RESET), .T_LOS_CYC(P_LOS)) tcs_sequencer_i (
        .REF_CLK(ref_clk), .RST(rst), .LASER_DISABLE(laser_disable), .RATE_SELECT_LOW(rsl),
        .RATE_SELECT_HIGH(rsh), .LASER_FAULT_RAW(fault_raw), .SIGNAL_LOST_RAW(lost_raw), .TX_ENABLE(tx_en),
        .LASER_FAULT(fault), .SIGNAL_LOSS(loss), .RATE_STABLE(rate_ok), .HIGH_POWER(hi_pwr),
        .OPERATIONAL(oper), .MGMT_READY(ready), .IRQ(irq), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until ack is sampled, then released
    task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge ref_clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (i >= 20) n_mismatch++;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        check(q & m, e);
    endtask
    task automatic wait_out(input int b, input logic v, input int lim);
        int i;
        #1;
        i = 0;
        while (outs[b] !== v && i < lim) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        check({31'h0, outs[b]}, {31'h0, v});
    endtask
    initial begin
        #(40 * 3000);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h0);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
        wait_out(6, 1'b1, P_2W + 6);
        wait_out(5, 1'b1, P_START + 6);
        rd_chk(4'h4, 32'hFF, 32'h27);
        wr(4'h4, 32'hFF);
        rd_chk(4'h4, 32'hFF, 32'h27);
        rd_chk(4'h1, 32'hFFFFFFFF, 32'h0);
        $display("test startup done");
        tcs_host_model_i.set_disable(1'b1);
        wait_out(0, 1'b0, 3);
        tcs_host_model_i.set_disable(1'b0);
        wait_out(0, 1'b1, 4);
        wait_out(5, 1'b1, P_ON + 4);
        $display("test disable done");
        wr(4'h0, 32'h4);
        wait_out(4, 1'b1, P_HPE + 4);
        wr(4'h0, 32'h0);
        wait_out(4, 1'b0, P_PDOWN + 4);
        wr(4'h0, 32'h1);
        wr(4'h0, 32'h5);
        repeat (P_HPE + 6) @(posedge ref_clk);
        wait_out(4, 1'b0, 0);
        wait_out(4, 1'b1, P_COOLED);
        wr(4'h0, 32'h0);
        wait_out(4, 1'b0, P_PDOWN + 4);
        $display("test power done");
        tcs_host_model_i.set_rate(1'b1, 1'b0);
        wait_out(3, 1'b0, 4);
        wait_out(3, 1'b1, P_RS + 4);
        wr(4'h0, 32'h2);
        tcs_host_model_i.set_rate(1'b1, 1'b1);
        wait_out(3, 1'b0, 4);
        wait_out(3, 1'b1, P_RS_FC + 4);
        wr(4'h0, 32'h0);
        $display("test rate done");
        wr(4'h8, 32'hF);
        wr(4'hC, 32'h2);
        @(posedge ref_clk);
        lost_raw <= 1'b1;
        wait_out(2, 1'b1, P_LOS + 4);
        wait_out(7, 1'b1, 3);
        rd_chk(4'h8, 32'h2, 32'h2);
        wr(4'hC, 32'h0);
        wait_out(7, 1'b0, 2);
        wr(4'hC, 32'h2);
        wait_out(7, 1'b1, 2);
        wr(4'h8, 32'h2);
        wait_out(7, 1'b0, 2);
        @(posedge ref_clk);
        lost_raw <= 1'b0;
        wait_out(2, 1'b0, P_LOS + 4);
        wait_out(7, 1'b1, 3);
        wr(4'h8, 32'hF);
        $display("test loss done");
        wr(4'hC, 32'h1);
        @(posedge ref_clk);
        fault_raw <= 1'b1;
        wait_out(1, 1'b1, P_FAULT + 4);
        wait_out(7, 1'b1, 3);
        @(posedge ref_clk);
        fault_raw <= 1'b0;
        tcs_host_model_i.set_disable(1'b1);
        tcs_host_model_i.set_disable(1'b0);
        repeat (4) @(posedge ref_clk);
        wait_out(1, 1'b1, 0);
        tcs_host_model_i.clear_fault();
        wait_out(1, 1'b0, 4);
        wait_out(5, 1'b1, P_START + 6);
        $display("test fault done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        wait_out(6, 1'b0, 0);
        wait_out(5, 1'b0, 0);
        wait_out(6, 1'b1, P_2W + 6);
        $display("test restart done");
        print_verdict();
    end
endmodule
